//--- rtl/tcr_top.sv
// Trigger, converter source and sampling clock routing configuration
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module tcr_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [tcr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [tcr_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [tcr_pkg::DATA_W-1:0] reg_rdata,
	// Converter data
	input wire tcr_pkg::tcr_data_in_type conv_in,
	output tcr_pkg::tcr_data_out_type conv_out,
	// Triggers, active low; connector output enable active high
	input wire logic bus_trigger_n,
	input wire logic level_trigger_n,
	input wire logic gen_trigger_n,
	input wire logic connector_trigger_n_in,
	output logic connector_trigger_n_out,
	output logic connector_trigger_n_oe,
	// Starts
	output logic acq_start,
	output logic gen_start,
	// Sampling clock routing
	input wire logic own_sample_tick,
	input wire logic bus_sample_tick,
	output logic [tcr_pkg::SLOTS-1:0] follower_mask,
	output logic clock_drive_en,
	output logic sample_tick,
	output logic scan_rate_locked
);
	import tcr_pkg::*;

	typedef struct packed {
		logic converter_data_select;
		logic shared_trigger_select;
		logic trigger_out_enable;
		logic trig_src_level;
		logic [SLOTS-1:0] follower_slot_list;
		logic [SLOTS-1:0] follower_mask;
		logic clock_master_select;
		logic [CNT_W-1:0] follower_count;
		logic is_follower;
		logic [DATA_W-1:0] board_kind_code;
		logic [DATA_W-1:0] rdata;
		logic ext_acq;
		logic ext_gen;
		logic trig_out_n;
		logic tick;
	} tcr_state_type;

	tcr_state_type state_reg;
	tcr_state_type state_next;
	logic wr_ctrl;
	logic wr_follow;
	logic wr_apply;
	logic wr_arm;
	logic apply_master;
	logic [CNT_W-1:0] apply_count;
	logic acq_trig_n;
	logic acq_armed;
	logic gen_armed;
	logic [DATA_W-1:0] rd_word;

	assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
	assign wr_follow = reg_wr && (reg_addr == OFS_FOLLOW);
	assign wr_apply = reg_wr && (reg_addr == OFS_APPLY);
	assign wr_arm = reg_wr && (reg_addr == OFS_ARM);
	assign apply_master = reg_wdata[BIT_MASTER];
	assign apply_count = reg_wdata[CNT_LO +: CNT_W];

	// Trigger into the acquisition circuitry
	assign acq_trig_n = state_reg.trig_src_level ? level_trigger_n : bus_trigger_n;

	tcr_dac_mux u_dac_mux (
		.core_clk(core_clk),
		.rst(rst),
		.live_select(state_reg.converter_data_select),
		.din(conv_in),
		.dout(conv_out)
	);

	tcr_trig_gate u_trig_gate (
		.core_clk(core_clk),
		.rst(rst),
		.share(state_reg.shared_trigger_select),
		.arm_acq_set(wr_arm && reg_wdata[BIT_ARM_ACQ]),
		.arm_gen_set(wr_arm && reg_wdata[BIT_ARM_GEN]),
		.ext_acq(reg_wdata[BIT_EXT_ACQ]),
		.ext_gen(reg_wdata[BIT_EXT_GEN]),
		.disarm(wr_ctrl),
		.acq_trig_n(acq_trig_n),
		.gen_trig_n(gen_trigger_n),
		.acq_start(acq_start),
		.gen_start(gen_start),
		.acq_armed(acq_armed),
		.gen_armed(gen_armed)
	);

	always_comb begin
		rd_word = ZERO_WORD;
		case (reg_addr)
			OFS_CTRL: begin
				rd_word[BIT_SRC] = state_reg.converter_data_select;
				rd_word[BIT_SHARE] = state_reg.shared_trigger_select;
				rd_word[BIT_TDRV] = state_reg.trigger_out_enable;
				rd_word[BIT_TSEL] = state_reg.trig_src_level;
			end
			OFS_FOLLOW: begin
				rd_word = state_reg.follower_slot_list;
			end
			OFS_APPLY: begin
				rd_word[BIT_MASTER] = state_reg.clock_master_select;
				rd_word[CNT_LO +: CNT_W] = state_reg.follower_count;
			end
			OFS_STATUS: begin
				rd_word = state_reg.follower_mask;
			end
			OFS_KIND: begin
				rd_word = state_reg.board_kind_code;
			end
			OFS_ARM: begin
				rd_word[BIT_ARM_ACQ] = acq_armed;
				rd_word[BIT_ARM_GEN] = gen_armed;
				rd_word[BIT_EXT_ACQ] = state_reg.ext_acq;
				rd_word[BIT_EXT_GEN] = state_reg.ext_gen;
			end
			default: begin
				rd_word = ZERO_WORD;
			end
		endcase
	end

	always_comb begin
		state_next = state_reg;
		state_next.rdata = reg_rd ? rd_word : ZERO_WORD;
		if (wr_ctrl) begin
			state_next.converter_data_select = reg_wdata[BIT_SRC];
			state_next.shared_trigger_select = reg_wdata[BIT_SHARE];
			state_next.trigger_out_enable = reg_wdata[BIT_TDRV];
			state_next.trig_src_level = reg_wdata[BIT_TSEL];
		end
		if (wr_follow) begin
			state_next.follower_slot_list = reg_wdata;
		end
		if (wr_arm) begin
			state_next.ext_acq = reg_wdata[BIT_EXT_ACQ];
			state_next.ext_gen = reg_wdata[BIT_EXT_GEN];
		end
		if (wr_apply) begin
			state_next.clock_master_select = apply_master;
			state_next.follower_count = apply_count;
			if (apply_master) begin
				if (apply_count == ZERO_CNT) begin
					state_next.follower_mask = ZERO_SLOTS;
				end else begin
					state_next.follower_mask = state_reg.follower_slot_list;
				end
			end
			// Master 0 leaves the mask untouched, list unused
		end
		// Sampling clock taken from bus while a follower
		state_next.tick = state_reg.is_follower ? bus_sample_tick : own_sample_tick;
		state_next.trig_out_n = acq_trig_n;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.board_kind_code <= KIND_DEFAULT;
			state_reg.trig_out_n <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata = state_reg.rdata;
	assign follower_mask = state_reg.follower_mask;
	assign clock_drive_en = |state_reg.follower_mask;
	assign sample_tick = state_reg.tick;
	assign scan_rate_locked = state_reg.is_follower;
	assign connector_trigger_n_out = state_reg.trig_out_n;
	assign connector_trigger_n_oe = state_reg.trigger_out_enable;
endmodule

//--- rtl/tcr_pkg.sv
// Constants, register map and carrier types of the trigger and clock routing block
// Notes on behaviour
// - Data source setting 0 feeds the output converters from the output FIFO, and is the reset value.
// - Data source setting 1 sends each freshly sampled input word straight to the output converters.
// - Shared trigger off lets acquisition and generation take their own triggers independently.
// - Shared trigger on ignores an external trigger edge while only one of the two operations is armed.
// - Shared trigger on with both armed starts acquisition and generation in the same cycle.
// - In multi-frame sharing each accepted trigger starts the next frame and next waveform cycle together.
// - Trigger out enable 0 leaves the active-low connector line undriven; 1 drives it with the bus or level trigger.
// - Acquisition starts on a falling edge of the trigger it receives.
// - Clock master setting 0 leaves the clock drive as it is; 1 reloads it from the follower list.
// - Each listed follower slot takes its sampling clock from the timing bus.
// - Follower scan-rate settings have no effect; master reconfigured with count 0 frees all followers.
// - The follower list is ignored when clock master is 0 or follower count is 0.
// - A readable board kind code exists, and all ones means empty slot or unknown device.
package tcr_pkg;

	localparam int DATA_W = 16;
	localparam int SLOTS = 16;
	localparam int ADDR_W = 4;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_FOLLOW = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_APPLY = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_KIND = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_ARM = 4'h5;

	// Control field positions
	localparam int BIT_SRC = 0;
	localparam int BIT_SHARE = 1;
	localparam int BIT_TDRV = 2;
	localparam int BIT_TSEL = 3;
	// Arm register field positions
	localparam int BIT_ARM_ACQ = 0;
	localparam int BIT_ARM_GEN = 1;
	localparam int BIT_EXT_ACQ = 2;
	localparam int BIT_EXT_GEN = 3;
	// Apply register fields
	localparam int BIT_MASTER = 0;
	localparam int CNT_LO = 8;
	localparam int CNT_W = 5;

	// Arbitrary neutral board kind; all ones marks an empty slot
	localparam logic [DATA_W-1:0] KIND_DEFAULT = 16'h00_5A;
	localparam logic [DATA_W-1:0] KIND_NONE = 16'hFFFF;

	localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
	localparam logic [SLOTS-1:0] ZERO_SLOTS = 16'h0000;
	localparam logic [CNT_W-1:0] ZERO_CNT = 5'h00;

	typedef enum logic [1:0] {
		TCR_SRC_FIFO = 2'b00,
		TCR_SRC_LIVE = 2'b01
	} tcr_src_type;

	typedef struct packed {
		logic [DATA_W-1:0] addr_pad;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} tcr_bus_type;

	typedef struct packed {
		logic [DATA_W-1:0] fifo_word;
		logic fifo_valid;
		logic [DATA_W-1:0] adc_word;
		logic adc_valid;
	} tcr_data_in_type;

	typedef struct packed {
		logic [DATA_W-1:0] word;
		logic valid;
		logic fifo_pop;
	} tcr_data_out_type;

	function automatic logic fall_edge(input logic prev_n, input logic now_n);
		return prev_n & ~now_n;
	endfunction

endpackage

//--- rtl/tcr_dac_mux.sv
// Converter data source selector
`timescale 1ns/1ps
module tcr_dac_mux (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control
	input wire logic live_select,
	// Data
	input wire tcr_pkg::tcr_data_in_type din,
	output tcr_pkg::tcr_data_out_type dout
);
	import tcr_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] word;
		logic valid;
	} tcr_mux_state_type;

	tcr_mux_state_type state_reg;
	tcr_mux_state_type state_next;

	always_comb begin
		state_next.valid = 1'b0;
		state_next.word = state_reg.word;
		if (live_select) begin
			if (din.adc_valid) begin
				state_next.word = din.adc_word;
				state_next.valid = 1'b1;
			end
		end else if (din.fifo_valid) begin
			state_next.word = din.fifo_word;
			state_next.valid = 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign dout.word = state_reg.word;
	assign dout.valid = state_reg.valid;
	assign dout.fifo_pop = ~live_select & din.fifo_valid;
endmodule

//--- rtl/tcr_trig_gate.sv
// Shared external trigger gate for acquisition and generation
`timescale 1ns/1ps
module tcr_trig_gate (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control
	input wire logic share,
	input wire logic arm_acq_set,
	input wire logic arm_gen_set,
	input wire logic ext_acq,
	input wire logic ext_gen,
	input wire logic disarm,
	// Trigger sources, active low
	input wire logic acq_trig_n,
	input wire logic gen_trig_n,
	// Starts and state
	output logic acq_start,
	output logic gen_start,
	output logic acq_armed,
	output logic gen_armed
);
	import tcr_pkg::*;

	typedef struct packed {
		logic acq_prev_n;
		logic gen_prev_n;
		logic acq_armed;
		logic gen_armed;
		logic acq_start;
		logic gen_start;
	} tcr_gate_state_type;

	tcr_gate_state_type state_reg;
	tcr_gate_state_type state_next;
	logic acq_edge;
	logic gen_edge;

	always_comb begin
		acq_edge = fall_edge(state_reg.acq_prev_n, acq_trig_n);
		gen_edge = fall_edge(state_reg.gen_prev_n, gen_trig_n);
		state_next = state_reg;
		state_next.acq_prev_n = acq_trig_n;
		state_next.gen_prev_n = gen_trig_n;
		state_next.acq_start = 1'b0;
		state_next.gen_start = 1'b0;
		if (share) begin
			// One trigger feeds both; only accepted when both armed
			if (acq_edge && state_reg.acq_armed && state_reg.gen_armed) begin
				state_next.acq_start = 1'b1;
				state_next.gen_start = 1'b1;
				state_next.acq_armed = 1'b0;
				state_next.gen_armed = 1'b0;
			end
		end else begin
			if (acq_edge && state_reg.acq_armed) begin
				state_next.acq_start = 1'b1;
				state_next.acq_armed = 1'b0;
			end
			if (gen_edge && state_reg.gen_armed) begin
				state_next.gen_start = 1'b1;
				state_next.gen_armed = 1'b0;
			end
		end
		if (disarm) begin
			state_next.acq_armed = 1'b0;
			state_next.gen_armed = 1'b0;
		end
		// Arming while sharing needs the external option
		if (arm_acq_set && (!share || ext_acq)) begin
			state_next.acq_armed = 1'b1;
		end
		if (arm_gen_set && (!share || ext_gen)) begin
			state_next.gen_armed = 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= 6'b11_0000;
		end else begin
			state_reg <= state_next;
		end
	end

	assign acq_start = state_reg.acq_start;
	assign gen_start = state_reg.gen_start;
	assign acq_armed = state_reg.acq_armed;
	assign gen_armed = state_reg.gen_armed;
endmodule

//--- verification/tcr_checker.sv
// Port-level assertions for the routing block
`timescale 1ns/1ps
module tcr_checker (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [tcr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [tcr_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [tcr_pkg::DATA_W-1:0] reg_rdata,
	// Data and starts
	input wire tcr_pkg::tcr_data_in_type conv_in,
	input wire tcr_pkg::tcr_data_out_type conv_out,
	input wire logic acq_start,
	input wire logic gen_start,
	input wire logic connector_trigger_n_oe,
	// Clock routing
	input wire logic [tcr_pkg::SLOTS-1:0] follower_mask,
	input wire logic clock_drive_en,
	input wire logic own_sample_tick,
	input wire logic sample_tick,
	input wire logic scan_rate_locked
);
	import tcr_pkg::*;
	logic src_q;
	logic share_q;
	wire ctrl_wr = reg_wr && reg_addr == OFS_CTRL;
	wire apply_wr = reg_wr && reg_addr == OFS_APPLY;
	// Shadow of the control settings
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			src_q <= 1'b0;
			share_q <= 1'b0;
		end else if (ctrl_wr) begin
			src_q <= reg_wdata[BIT_SRC];
			share_q <= reg_wdata[BIT_SHARE];
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_kind; reg_rd && reg_addr == OFS_KIND |=> reg_rdata == KIND_DEFAULT; endproperty
	property p_fifo; !src_q && conv_in.fifo_valid |=> conv_out.word == $past(conv_in.fifo_word);
	endproperty
	property p_live; src_q && conv_in.adc_valid |=> conv_out.word == $past(conv_in.adc_word);
	endproperty
	property p_share; share_q && (acq_start || gen_start) |-> acq_start && gen_start; endproperty
	property p_oe; ctrl_wr |=> connector_trigger_n_oe == $past(reg_wdata[BIT_TDRV]); endproperty
	property p_keep; apply_wr && !reg_wdata[BIT_MASTER] |=> $stable(follower_mask); endproperty
	property p_free; apply_wr && reg_wdata[BIT_MASTER] && reg_wdata[CNT_LO+:CNT_W] == ZERO_CNT
		|=> follower_mask == ZERO_SLOTS; endproperty
	property p_drive; clock_drive_en == (follower_mask != ZERO_SLOTS); endproperty
	property p_tick; !rst |=> sample_tick == $past(own_sample_tick) && !scan_rate_locked;
	endproperty
	a_kind: assert property (p_kind) else $error("board kind read wrong");
	a_fifo: assert property (p_fifo) else $error("fifo word not passed");
	a_live: assert property (p_live) else $error("sampled word not passed");
	a_share: assert property (p_share) else $error("shared starts apart");
	a_oe: assert property (p_oe) else $error("trigger out enable wrong");
	a_keep: assert property (p_keep) else $error("mask changed without master");
	a_free: assert property (p_free) else $error("followers not freed");
	a_drive: assert property (p_drive) else $error("clock drive enable wrong");
	a_tick: assert property (p_tick) else $error("own tick not used");
	c_share: cover property (acq_start && gen_start);
	c_live: cover property (src_q && conv_in.adc_valid);
	c_mask: cover property (apply_wr && follower_mask != ZERO_SLOTS);
endmodule
bind tcr_top tcr_checker u_chk (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .conv_in, .conv_out, .acq_start, .gen_start, .connector_trigger_n_oe,
	.follower_mask, .clock_drive_en, .own_sample_tick, .sample_tick, .scan_rate_locked);

//--- verification/tcr_far.sv
// Far-side model: trigger sources and sampling ticks
`timescale 1ns/1ps
module tcr_far (
	// Clock
	input wire logic core_clk,
	// Requests: bit0 bus, bit1 level, bit2 generation
	input wire logic [2:0] fire,
	// Trigger lines, active low, idle high
	output logic bus_trigger_n,
	output logic level_trigger_n,
	output logic gen_trigger_n,
	// Sampling ticks
	output logic own_sample_tick,
	output logic bus_sample_tick
);
	logic [2:0] low_n = 3'h7;
	logic [1:0] cnt = 2'h0;
	logic [1:0] tick = 2'h0;
	assign {gen_trigger_n, level_trigger_n, bus_trigger_n} = low_n;
	assign {bus_sample_tick, own_sample_tick} = tick;
	// One falling edge, held low four cycles
	always @(posedge core_clk) begin
		tick <= tick + 2'h1;
		if (fire != 3'h0) begin
			low_n <= ~fire;
			cnt <= 2'h3;
		end else if (cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
		end else begin
			low_n <= 3'h7;
		end
	end
endmodule

//--- verification/tb.sv
// Self-checking bench for the routing block
`timescale 1ns/1ps
module tb;
	import tcr_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [DATA_W-1:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	tcr_data_in_type conv_in = '0;
	tcr_data_out_type conv_out;
	logic [2:0] fire = 3'h0;
	logic bus_trigger_n, level_trigger_n, gen_trigger_n, own_sample_tick, bus_sample_tick;
	logic connector_trigger_n_out, connector_trigger_n_oe, connector_trigger_n_in;
	logic acq_start, gen_start, clock_drive_en, sample_tick, scan_rate_locked;
	logic [SLOTS-1:0] follower_mask;
	int fail_count = 0;
	int comparisons = 0;
	int cyc = 0;
	int n_acq = 0;
	int n_gen = 0;
	int n_both = 0;
	int n_conn = 0;
	// Pulled-up connector line
	assign connector_trigger_n_in = connector_trigger_n_oe ? connector_trigger_n_out : 1'b1;
	initial forever #2 core_clk = ~core_clk;
	tcr_top u_dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.conv_in, .conv_out, .bus_trigger_n, .level_trigger_n, .gen_trigger_n,
		.connector_trigger_n_in, .connector_trigger_n_out, .connector_trigger_n_oe,
		.acq_start, .gen_start, .own_sample_tick, .bus_sample_tick, .follower_mask,
		.clock_drive_en, .sample_tick, .scan_rate_locked);
	tcr_far u_far (.core_clk, .fire, .bus_trigger_n, .level_trigger_n, .gen_trigger_n,
		.own_sample_tick, .bus_sample_tick);
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Start and connector monitor, hang limit
	always @(posedge core_clk) begin
		cyc++;
		n_acq += int'(acq_start === 1'b1);
		n_gen += int'(gen_start === 1'b1);
		n_both += int'(acq_start === 1'b1 && gen_start === 1'b1);
		n_conn += int'(connector_trigger_n_in === 1'b0);
		if (cyc == 3000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		cmp(reg_rdata, exp);
	endtask
	// Fire lines, then count starts and connector low cycles
	task automatic trig(input logic [2:0] f, input int ea, input int eg, input int ec);
		int a0, g0, b0, c0;
		a0 = n_acq;
		g0 = n_gen;
		b0 = n_both;
		c0 = n_conn;
		@(posedge core_clk);
		fire <= f;
		@(posedge core_clk);
		fire <= 3'h0;
		repeat (10) @(posedge core_clk);
		cmp(16'(n_acq - a0), 16'(ea));
		cmp(16'(n_gen - g0), 16'(eg));
		cmp(16'(n_both - b0), 16'(ea * eg));
		cmp(16'(n_conn - c0), 16'(ec));
	endtask
	task automatic t_reset();
		rd(OFS_KIND, KIND_DEFAULT);
		rd(OFS_CTRL, ZERO_WORD);
		rd(OFS_STATUS, ZERO_WORD);
		rd(4'hF, ZERO_WORD);
		cmp(16'(connector_trigger_n_oe), 16'h0000);
	endtask
	task automatic t_src();
		wr(OFS_CTRL, 16'h0000);
		conv_in <= '{16'hA5A5, 1'b1, 16'h3C3C, 1'b1};
		repeat (3) @(posedge core_clk);
		#1;
		cmp(conv_out.word, 16'hA5A5);
		cmp(16'(conv_out.valid), 16'h0001);
		cmp(16'(conv_out.fifo_pop), 16'h0001);
		wr(OFS_CTRL, 16'h0001);
		repeat (3) @(posedge core_clk);
		#1;
		cmp(conv_out.word, 16'h3C3C);
		cmp(16'(conv_out.valid), 16'h0001);
		cmp(16'(conv_out.fifo_pop), 16'h0000);
	endtask
	task automatic t_trig();
		wr(OFS_CTRL, 16'h0000);
		wr(OFS_ARM, 16'h0003);
		trig(3'h1, 1, 0, 0);
		trig(3'h4, 0, 1, 0);
		wr(OFS_CTRL, 16'h0002);
		wr(OFS_ARM, 16'h0003);
		trig(3'h1, 0, 0, 0);
		wr(OFS_ARM, 16'h0005);
		trig(3'h1, 0, 0, 0);
		wr(OFS_ARM, 16'h000A);
		trig(3'h1, 1, 1, 0);
		wr(OFS_ARM, 16'h000F);
		trig(3'h1, 1, 1, 0);
		wr(OFS_CTRL, 16'h0004);
		#1;
		cmp(16'(connector_trigger_n_oe), 16'h0001);
		wr(OFS_ARM, 16'h0001);
		trig(3'h1, 1, 0, 4);
		wr(OFS_CTRL, 16'h000C);
		wr(OFS_ARM, 16'h0001);
		trig(3'h2, 1, 0, 4);
		trig(3'h1, 0, 0, 0);
	endtask
	task automatic t_clock();
		wr(OFS_FOLLOW, 16'h0A05);
		wr(OFS_APPLY, 16'h0201);
		rd(OFS_STATUS, 16'h0A05);
		cmp(16'(clock_drive_en), 16'h0001);
		wr(OFS_FOLLOW, 16'h00FF);
		wr(OFS_APPLY, 16'h0200);
		rd(OFS_STATUS, 16'h0A05);
		wr(OFS_APPLY, 16'h0001);
		rd(OFS_STATUS, ZERO_WORD);
		cmp(16'(clock_drive_en), 16'h0000);
		wr(OFS_APPLY, 16'h0301);
		rd(OFS_STATUS, 16'h00FF);
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_src();
		t_trig();
		t_clock();
		close_out();
	end
endmodule
